// ### rtl/poll_timer_pkg.sv
// package: register map, field layouts, reset values and timing constants
// assumes: shared by the poll timer top, the prescaler and the scheduler
package poll_timer_pkg;
  // byte addresses: printed offsets are not all multiples of four, so addr = 4*index
  localparam logic [7:0] idx_pin_function = 8'h03;
  localparam logic [7:0] idx_poll_control = 8'h07;
  localparam logic [7:0] idx_ref_timer = 8'h08;
  localparam logic [7:0] idx_off_low = 8'h09;
  localparam logic [7:0] idx_off_high = 8'h0a;
  localparam logic [7:0] idx_active = 8'h0b;
  localparam logic [7:0] idx_idle = 8'h0c;
  localparam logic [7:0] idx_on_time = 8'h0d;
  localparam logic [7:0] idx_status = 8'h0e;
  localparam int addr_lsb = 2;
  // reset values
  localparam logic [7:0] rst_pin_function = 8'h00;
  localparam logic [7:0] rst_poll_control = 8'h00;
  localparam logic [7:0] rst_ref_timer = 8'h01;
  localparam logic [7:0] rst_off_low = 8'h01;
  localparam logic [7:0] rst_off_high = 8'h00;
  localparam logic [7:0] rst_active = 8'h01;
  localparam logic [7:0] rst_idle = 8'h01;
  localparam logic [7:0] rst_on_time = 8'h01;
  // field layouts
  localparam int pin_select_bit = 0;
  localparam int active_idle_bit = 2;
  localparam int off_low_width = 8;
  localparam int off_high_width = 6;
  localparam int off_width = 14;
  localparam int active_width = 5;
  localparam int idle_width = 8;
  // timing: one prescaler tick every 64 system clocks, ref setting zero means 256
  localparam int prescale_cycles = 64;
  localparam int ref_width = 8;
  localparam int period_cnt_width = 9;
  localparam logic [8:0] count_zero_max = 9'h100;
  // scheduler states
  typedef enum logic [2:0] {
    st_on = 3'b001,
    st_off = 3'b010,
    st_idle = 3'b100
  } poll_state_t;
endpackage

// ### rtl/ref_timer_tick.sv
// ref_timer_tick: divides the system clock into one reference-timer period pulse
// assumes: setting is held stable by software; changes take effect at next wrap
`timescale 1ns/100ps
`default_nettype none
module ref_timer_tick (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [poll_timer_pkg::ref_width-1:0] reference_timer_setting,
  output logic tick
);
  import poll_timer_pkg::*;
  typedef struct packed {
    logic [5:0] pre;
    logic [ref_width-1:0] ref_cnt;
    logic tick;
  } tick_state_t;
  tick_state_t s, next_s;
  logic pre_wrap;
  logic [ref_width-1:0] ref_last;
  // 64-cycle prescaler then a count of setting prescaler ticks (zero counts 256)
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    pre_wrap = (s.pre == 6'(prescale_cycles - 1));
    ref_last = reference_timer_setting - 8'h01; // setting 0 wraps to 255 = 256 ticks
    next_s.pre = pre_wrap ? 6'h00 : s.pre + 6'h01;
    if (pre_wrap) begin
      if (s.ref_cnt >= ref_last) begin
        next_s.ref_cnt = 8'h00;
        next_s.tick = 1'b1;
      end else begin
        next_s.ref_cnt = s.ref_cnt + 8'h01;
      end
    end
  end
  // register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick = s.tick;
endmodule
`default_nettype wire

// ### rtl/poll_scheduler.sv
// poll_scheduler: on/off phases of a master period and active/idle period gating
// assumes: tick is one-cycle wide, one per reference-timer period
`timescale 1ns/100ps
`default_nettype none
module poll_scheduler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic [poll_timer_pkg::off_width-1:0] off_time_count,
  input wire logic [poll_timer_pkg::ref_width-1:0] on_time_count,
  input wire logic [poll_timer_pkg::active_width-1:0] active_period_count,
  input wire logic [poll_timer_pkg::idle_width-1:0] idle_period_count,
  input wire logic active_idle_enable,
  output logic receiver_active,
  output logic in_idle
);
  import poll_timer_pkg::*;
  typedef struct packed {
    poll_state_t st;
    logic [off_width:0] phase_cnt;
    logic [period_cnt_width-1:0] period_cnt;
  } sched_state_t;
  sched_state_t s, next_s;
  logic [off_width:0] off_len;
  logic [off_width:0] on_len;
  logic [off_width:0] phase_len;
  logic [period_cnt_width-1:0] active_len;
  logic [period_cnt_width-1:0] idle_len;
  logic phase_end;
  // phase lengths; zero fields select their maximum
  always_comb begin
    off_len = (off_time_count == '0) ? 15'h4000 : {1'b0, off_time_count};
    on_len = (on_time_count == '0) ? 15'h0100 : {7'h00, on_time_count};
    active_len = (active_period_count == '0) ? count_zero_max : {4'h0, active_period_count};
    idle_len = (idle_period_count == '0) ? count_zero_max : {1'b0, idle_period_count};
    // an idle master period keeps the receiver off for a whole on plus off length
    phase_len = (s.st == st_on) ? on_len : off_len;
    if (s.st == st_idle) begin
      phase_len = (off_width+1)'(off_len + on_len);
    end
  end
  // master period: on phase then off phase; idle periods skip the on phase
  always_comb begin
    next_s = s;
    phase_end = 1'b0;
    if (tick) begin
      if (s.phase_cnt + 15'h0001 >= phase_len) begin
        phase_end = 1'b1;
        next_s.phase_cnt = '0;
      end else begin
        next_s.phase_cnt = s.phase_cnt + 15'h0001;
      end
    end
    case (s.st)
      st_on: begin
        if (phase_end) begin
          next_s.st = st_off;
        end
      end
      st_off, st_idle: begin
        // end of a master period: choose whether the next one polls
        if (phase_end) begin
          if (!active_idle_enable) begin
            next_s.st = st_on;
            next_s.period_cnt = '0;
          end else if (s.st == st_off) begin
            if (s.period_cnt + 9'h001 >= active_len) begin
              next_s.st = st_idle;
              next_s.period_cnt = '0;
            end else begin
              next_s.st = st_on;
              next_s.period_cnt = s.period_cnt + 9'h001;
            end
          end else begin
            if (s.period_cnt + 9'h001 >= idle_len) begin
              next_s.st = st_on;
              next_s.period_cnt = '0;
            end else begin
              next_s.period_cnt = s.period_cnt + 9'h001;
            end
          end
        end
      end
      default: begin
        next_s.st = st_on;
      end
    endcase
  end
  // register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{st: st_on, phase_cnt: '0, period_cnt: '0};
    end else begin
      s <= next_s;
    end
  end
  assign receiver_active = (s.st == st_on);
  assign in_idle = (s.st == st_idle);
endmodule
`default_nettype wire

// ### rtl/self_polling_period_timer.sv
// self_polling_period_timer: register file over AHB-Lite, polling schedule and pin mux
// assumes: single-word AHB-Lite transfers; rx_data_in is already on hclk
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Off-time bits 7:0 come from bits 7:0 of the low off-time register.
// - Off-time bits 13:8 come from bits 5:0 of the high off-time register.
// - The off phase lasts the count times one reference-timer period.
// - An off-time count of zero gives 16384 reference-timer periods.
// - Active-period values 1 to 31 give that many polling master periods.
// - An active-period value of zero gives 256 master periods.
// - Idle-period value n gives n idle master periods.
// - An idle-period value of zero gives 256 idle master periods.
// - The receiver-active pin is high while the receiver is active.
// - Pin select 0 puts receiver-active on the pin, 1 puts received data on it.
// - The reference period is 64 clocks times the setting, zero meaning 256.
// - Active/idle counts apply only with active-idle enable set, else every period polls.
module self_polling_period_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_data_in,
  output logic rx_run_pin
);
  import poll_timer_pkg::*;
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic [7:0] pin_function;
    logic [7:0] poll_control;
    logic [7:0] ref_timer;
    logic [7:0] off_low;
    logic [7:0] off_high;
    logic [7:0] active;
    logic [7:0] idle;
    logic [7:0] on_time;
    logic pin_out;
  } top_state_t;
  top_state_t s, next_s;
  logic tick;
  logic receiver_active;
  logic in_idle;
  logic take;
  logic [7:0] a_idx;
  logic [off_width-1:0] off_time_count;
  // ==========================================================
  // prescaler and scheduler
  ref_timer_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .reference_timer_setting(s.ref_timer),
    .tick(tick)
  );
  assign off_time_count = {s.off_high[off_high_width-1:0], s.off_low[off_low_width-1:0]};
  poll_scheduler u_sched (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .off_time_count(off_time_count),
    .on_time_count(s.on_time),
    .active_period_count(s.active[active_width-1:0]),
    .idle_period_count(s.idle[idle_width-1:0]),
    .active_idle_enable(s.poll_control[active_idle_bit]),
    .receiver_active(receiver_active),
    .in_idle(in_idle)
  );
  // ==========================================================
  // bus slave: address phase captured, write data stored in the data phase
  always_comb begin
    next_s = s;
    take = hsel && hready && htrans[1];
    a_idx = haddr[addr_lsb+7:addr_lsb];
    if (s.wr_pend) begin
      if (s.wr_idx == idx_pin_function) begin
        next_s.pin_function = hwdata[7:0];
      end else if (s.wr_idx == idx_poll_control) begin
        next_s.poll_control = hwdata[7:0];
      end else if (s.wr_idx == idx_ref_timer) begin
        next_s.ref_timer = hwdata[7:0];
      end else if (s.wr_idx == idx_off_low) begin
        next_s.off_low = hwdata[7:0];
      end else if (s.wr_idx == idx_off_high) begin
        next_s.off_high = hwdata[7:0];
      end else if (s.wr_idx == idx_active) begin
        next_s.active = hwdata[7:0];
      end else if (s.wr_idx == idx_idle) begin
        next_s.idle = hwdata[7:0];
      end else if (s.wr_idx == idx_on_time) begin
        next_s.on_time = hwdata[7:0];
      end
    end
    next_s.wr_pend = take && hwrite && (haddr[31:addr_lsb+8] == '0); // unmapped writes dropped
    next_s.wr_idx = a_idx;
    // reads: only readable registers answer, others and unmapped read zero
    if (take && !hwrite) begin
      if (haddr[31:addr_lsb+8] != '0) begin
        next_s.rdata = '0;
      end else if (a_idx == idx_pin_function) begin
        next_s.rdata = {24'h000000, s.pin_function};
      end else if (a_idx == idx_status) begin
        next_s.rdata = {29'h00000000, in_idle, receiver_active, rx_data_in};
      end else begin
        next_s.rdata = '0;
      end
    end
    // output pin function select
    next_s.pin_out = s.pin_function[pin_select_bit] ? rx_data_in : receiver_active;
  end
  // register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{wr_pend: 1'b0, wr_idx: 8'h00, rdata: 32'h00000000,
             pin_function: rst_pin_function, poll_control: rst_poll_control,
             ref_timer: rst_ref_timer, off_low: rst_off_low, off_high: rst_off_high,
             active: rst_active, idle: rst_idle, on_time: rst_on_time, pin_out: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rx_run_pin = s.pin_out;
endmodule
`default_nettype wire

// ### test/poll_timer_checker.sv
// checker: bus and pin properties of the poll timer top
// assumes: bound to the top; hready is tied to hreadyout
`timescale 1ns/100ps
`default_nettype none
module poll_timer_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_data_in,
  input wire logic rx_run_pin
);
  logic rd, wr, sel, sel_d;
  logic [31:0] adr;
  logic [15:0] hi, lo;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ====
  // data phase tracking, select shadow and run lengths
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd <= 1'b0;
      wr <= 1'b0;
      adr <= 32'h0;
      sel <= 1'b0;
      sel_d <= 1'b0;
      hi <= 16'hffff;
      lo <= 16'hffff;
    end else begin
      rd <= hsel && hready && htrans[1] && !hwrite;
      wr <= hsel && hready && htrans[1] && hwrite;
      adr <= haddr;
      sel_d <= sel;
      if (wr && adr == 32'h0000000c) sel <= hwdata[0];
      hi <= (sel || sel_d) ? 16'hffff : !rx_run_pin ? 16'h0 : hi + {15'h0, hi != 16'hffff};
      lo <= (sel || sel_d) ? 16'hffff : rx_run_pin ? 16'h0 : lo + {15'h0, lo != 16'hffff};
    end
  end
  // ====
  // assertions
  a_bus_ready: assert property (hreadyout) else $error("hreadyout low");
  a_bus_okay: assert property (!hresp) else $error("hresp not okay");
  a_rxd_follow: assert property (sel && sel_d |-> rx_run_pin == $past(rx_data_in))
    else $error("pin not tracking data");
  a_sel_readback: assert property (rd && adr == 32'h0000000c |-> hrdata == {31'h0, sel})
    else $error("select readback wrong");
  a_wo_zero: assert property (rd && adr == 32'h00000024 |-> hrdata == 32'h0)
    else $error("write-only read not zero");
  a_unmapped_zero: assert property (rd && adr[31:10] != 22'h0 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd |-> $stable(hrdata)) else $error("hrdata moved");
  a_on_min: assert property ($fell(rx_run_pin) |-> hi >= 16'h0040)
    else $error("on phase too short");
  a_off_min: assert property ($rose(rx_run_pin) |-> lo >= 16'h0040)
    else $error("off phase too short");
  c_sel_data: cover property (sel && rx_run_pin);
  c_on_end: cover property ($fell(rx_run_pin));
  c_unmapped: cover property (rd && adr[31:10] != 22'h0);
endmodule
`default_nettype wire

// ### test/rf_front_end.sv
// rf_front_end: external amplifier following the receiver-active pin
// assumes: pin synchronous to hclk; also supplies demodulated data
`timescale 1ns/100ps
`default_nettype none
module rf_front_end (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rx_run,
  output var logic rx_data,
  output var int on_len,
  output var int off_len,
  output var int rises
);
  int run;
  logic last;
  logic [7:0] pat;
  // ====
  // data pattern changes every cycle; run lengths of the enable line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pat <= 8'h5a;
      rx_data <= 1'b0;
      last <= 1'b0;
      run <= 0;
      on_len <= 0;
      off_len <= 0;
      rises <= 0;
    end else begin
      pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
      rx_data <= pat[7];
      last <= rx_run;
      run <= (rx_run != last) ? 1 : run + 1;
      if (rx_run && !last) off_len <= run;
      if (!rx_run && last) on_len <= run;
      if (rx_run && !last) rises <= rises + 1;
    end
  end
endmodule
`default_nettype wire

// ### test/self_polling_period_timer_tb.sv
// self_polling_period_timer_tb: register and schedule tests over AHB-Lite
// assumes: checker and front end model compiled before this file
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module self_polling_period_timer_tb;
  import poll_timer_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, rx_data_in, rx_run_pin, prevd;
  int miscompares, total_checks, on_len, off_len, rises, nr;
  int act[2] = '{2, 1};
  int idl[2] = '{1, 3};
  int win[2] = '{1536, 2048};
  int cnt[2] = '{8, 4};
  always #50 hclk = ~hclk;
  self_polling_period_timer u_self_polling_period_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_data_in(rx_data_in), .rx_run_pin(rx_run_pin));
  rf_front_end u_rf_front_end (.hclk(hclk), .hresetn(hresetn), .rx_run(rx_run_pin), .rx_data(rx_data_in),
    .on_len(on_len), .off_len(off_len), .rises(rises));
  // ====
  // bus access, waits and verdict
  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // rises of the pin over span cycles, read clear of the edge that updates the count
  task automatic rises_in(input int settle, input int span, output int n);
    int r;
    tick(settle);
    #1;
    r = rises;
    tick(span);
    #1;
    n = rises - r;
    @(posedge hclk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ====
  // test sequence
  initial begin
    tick(8);
    hresetn <= 1'b1;
    tick(1);
    xfer(ad(idx_pin_function), 1'b0, 32'h0);
    `CHK(rd, {24'h0, rst_pin_function})
    xfer(ad(idx_off_low), 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    xfer(32'h00000400, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    tick(400);
    `CHK(on_len, prescale_cycles)
    `CHK(off_len, prescale_cycles)
    xfer(ad(idx_off_low), 1'b1, 32'h3);
    tick(600);
    `CHK(off_len, 3 * prescale_cycles)
    xfer(ad(idx_off_high), 1'b1, 32'h1);
    xfer(ad(idx_off_low), 1'b1, 32'h0);
    tick(17000);
    `CHK(off_len, 256 * prescale_cycles)
    xfer(ad(idx_off_high), 1'b1, 32'h0);
    xfer(ad(idx_off_low), 1'b1, 32'h1);
    tick(17000);
    xfer(ad(idx_ref_timer), 1'b1, 32'h2);
    tick(1200);
    `CHK(on_len, 2 * prescale_cycles)
    `CHK(off_len, 2 * prescale_cycles)
    xfer(ad(idx_ref_timer), 1'b1, 32'h1);
    xfer(ad(idx_poll_control), 1'b1, 32'h1 << active_idle_bit);
    for (int i = 0; i < 2; i++) begin
      xfer(ad(idx_active), 1'b1, act[i]);
      xfer(ad(idx_idle), 1'b1, idl[i]);
      rises_in(1100, win[i], nr);
      `CHK(nr, cnt[i])
    end
    // active field zero keeps polling for many periods; idle field zero keeps the receiver off
    xfer(ad(idx_idle), 1'b1, 32'h1);
    xfer(ad(idx_active), 1'b1, 32'h0);
    rises_in(600, 1280, nr);
    `CHK(nr, 10)
    xfer(ad(idx_idle), 1'b1, 32'h0);
    xfer(ad(idx_active), 1'b1, 32'h1);
    rises_in(600, 1280, nr);
    `CHK(nr, 0)
    xfer(ad(idx_poll_control), 1'b1, 32'h0);
    rises_in(600, 1280, nr);
    `CHK(nr, 10)
    // off count zero is the longest off phase, so no rise for many periods
    xfer(ad(idx_off_low), 1'b1, 32'h0);
    rises_in(600, 2000, nr);
    `CHK(nr, 0)
    xfer(ad(idx_pin_function), 1'b1, 32'h1);
    xfer(ad(idx_pin_function), 1'b0, 32'h0);
    `CHK(rd, 32'h1)
    tick(2);
    #1;
    prevd = rx_data_in;
    repeat (16) begin
      @(posedge hclk);
      #1;
      `CHK(rx_run_pin, prevd)
      prevd = rx_data_in;
    end
    close_out();
  end
  // bounds a hang in any wait above
  initial begin
    tick(60000);
    miscompares++;
    close_out();
  end
endmodule
bind self_polling_period_timer poll_timer_checker u_poll_timer_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_data_in(rx_data_in), .rx_run_pin(rx_run_pin));
`default_nettype wire
